//--- inc/serial_format_cfg.svh
// Constants for the multiturn serial output formatter
`ifndef SERIAL_FORMAT_CFG_SVH
`define SERIAL_FORMAT_CFG_SVH

`define CFG_ADDR_W 3
`define REG_FORMAT_ADDR 3'h0
`define REG_WIDTH_ADDR 3'h1
`define REG_PERIODS_ADDR 3'h2
`define REG_OPTIONS_ADDR 3'h5

`define RST_FORMAT 8'h00
`define RST_WIDTH 8'h00
`define RST_PERIODS 8'h00
`define RST_OPTIONS 8'h00

`define BIT_CHAIN_MODE 0
`define BIT_MULTITURN_OUTPUT_CODING 1
`define BIT_SINGLETURN_INPUT_CODING 2
`define BIT_DIR 3
`define FLD_SHIFT_HI 7
`define FLD_SHIFT_LO 5
`define FLD_MTW_HI 4
`define FLD_MTW_LO 0
`define FLD_SYNC_HI 5
`define FLD_SYNC_LO 4
`define BIT_PERIOD_OUT 6

`define POS_W 3
`define POS_MAX 3'h7
`define POS_MIN 3'h0
`define SYNC_MAX 3'h3
`define MT_COUNT_W 40
`define MT_MIN_W 6'h09
`define IDX_W 8
`define IDX_W_SZ 6'h08
`define WORD_W 43
`define WORD_W_SZ 6'h2B

`endif

//--- inc/serial_format_pkg.sv
// Types for the multiturn serial output formatter
`include "serial_format_cfg.svh"

package serial_format_pkg;

    typedef enum logic
    {
        LINK_IDLE = 1'b0,
        LINK_SHIFT = 1'b1
    } link_state_e;

    typedef struct packed
    {
        logic [2:0] sens_s1;
        logic [2:0] sens_s2;
        logic ack_s1;
        logic ack_s2;
        logic [7:0] fmt;
        logic [7:0] wid;
        logic [7:0] per;
        logic [7:0] opt;
        logic [`POS_W-1:0] pos;
        logic pos_ok;
        logic [`IDX_W-1:0] idx;
        logic [`MT_COUNT_W-1:0] mt;
        logic [`WORD_W-1:0] pub_word;
        logic pub_tgl;
        logic [7:0] rd_data;
    } main_s;

    typedef struct packed
    {
        logic rst_s1;
        logic rst_s2;
        logic tgl_s1;
        logic tgl_s2;
        logic sel_s1;
        logic sel_s2;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        link_state_e state;
        logic ack_tgl;
        logic [`WORD_W-1:0] word;
        logic [`WORD_W-1:0] sh;
        logic gray_prev;
    } link_s;

endpackage

//--- src/multiturn_serial_output_format.sv
// Multiturn position formatter with serial readout and chain mode
//
// Contract
// (RQ1) Sensor signs give eight sectors per period
// (RQ2) Add 3-bit phase offset, 45 degree steps
// (RQ3) Direction bit inverts position and count
// (RQ4) Readout mode returns data, ignores chain input
// (RQ5) Chain mode shifts input through, MSB first
// (RQ6) Mode bit: 0 readout, 1 chain
// (RQ7) Chain input binary, or Gray when set
// (RQ8) Gray input in readout mode locks access
// (RQ9) Output fields binary, or Gray when set
// (RQ10) Revolution counter is forty bits wide
// (RQ11) Transmitted width is code plus nine
// (RQ12) Period index fills eight LSBs when enabled
// (RQ13) Zero to three sync bits follow data
// (RQ14) Readout mode works as stand-alone counter
// (RQ15) Serial modes active only with select low
// (RQ16) Sync bits are adjusted position MSBs
`timescale 1ns/10ps
`default_nettype none

`include "serial_format_cfg.svh"

module multiturn_serial_output_format
(
    // System
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Serial link, master clock domain
    input wire logic ssi_clk_in,
    input wire logic ssi_frame_in,
    input wire logic chain_serial_input_in,
    output logic ssi_data_out,
    // Sensor and mode pins
    input wire logic sensor_sin_pos_in,
    input wire logic sensor_cos_pos_in,
    input wire logic sensor_sin_gt_cos_in,
    input wire logic mode_select_in,
    // Configuration access
    input wire logic cfg_wr_in,
    input wire logic [`CFG_ADDR_W-1:0] cfg_addr_in,
    input wire logic [7:0] cfg_wr_data_in,
    input wire logic [`CFG_ADDR_W-1:0] cfg_rd_addr_in,
    output logic [7:0] cfg_rd_data_out,
    // Status
    output logic [`POS_W-1:0] position_out,
    output logic [`IDX_W-1:0] period_index_out,
    output logic [`MT_COUNT_W-1:0] mt_count_out,
    output logic slave_access_lock_out
);

    serial_format_pkg::main_s m_reg;
    serial_format_pkg::main_s m_next;
    serial_format_pkg::link_s l_reg;
    serial_format_pkg::link_s l_next;

    logic [1:0] quad;
    logic [`POS_W-1:0] raw_pos;
    logic [`POS_W-1:0] dir_pos;
    logic [`POS_W-1:0] adj_pos;
    logic step_up;
    logic step_dn;
    logic [5:0] mt_w;
    logic [5:0] cnt_w;
    logic [1:0] n_sync;
    logic [5:0] n_bits;
    logic idx_on;
    logic [`MT_COUNT_W-1:0] mt_trunc;
    logic [`MT_COUNT_W-1:0] mt_code;
    logic [`IDX_W-1:0] idx_code;
    logic [`MT_COUNT_W-1:0] field;
    logic [`POS_W-1:0] sync_bits;
    logic [`WORD_W-1:0] word;
    logic chain_in_bit;

    function automatic logic [`MT_COUNT_W-1:0] low_mask(input logic [5:0] n);
        low_mask = (`MT_COUNT_W'(1) << n) - `MT_COUNT_W'(1);
    endfunction

    function automatic logic [`MT_COUNT_W-1:0] to_gray(input logic [`MT_COUNT_W-1:0] v);
        to_gray = v ^ (v >> 1);
    endfunction

    // Sector from sign of sine, cosine and their magnitude compare
    always_comb
    begin
        unique case (m_reg.sens_s2[2:1])
            2'b11: quad = 2'h0;
            2'b10: quad = 2'h1;
            2'b00: quad = 2'h2;
            2'b01: quad = 2'h3;
        endcase
        raw_pos = {quad, m_reg.sens_s2[0] ^ quad[0]}; // [RQ1]
        dir_pos = m_reg.fmt[`BIT_DIR] ? (`POS_MIN - raw_pos) : raw_pos; // [RQ3]
        adj_pos = dir_pos + m_reg.wid[`FLD_SHIFT_HI:`FLD_SHIFT_LO]; // [RQ2]
        step_up = m_reg.pos_ok && (m_reg.pos == `POS_MAX) && (adj_pos == `POS_MIN);
        step_dn = m_reg.pos_ok && (m_reg.pos == `POS_MIN) && (adj_pos == `POS_MAX);
    end

    // Output word, left aligned so the first bit sits at the top
    always_comb
    begin
        mt_w = {1'b0, m_reg.wid[`FLD_MTW_HI:`FLD_MTW_LO]} + `MT_MIN_W; // [RQ11]
        idx_on = m_reg.opt[`BIT_PERIOD_OUT] && (m_reg.per != 8'h00); // [RQ12]
        cnt_w = idx_on ? (mt_w - `IDX_W_SZ) : mt_w;
        mt_trunc = m_reg.mt & low_mask(cnt_w);
        mt_code = m_reg.fmt[`BIT_MULTITURN_OUTPUT_CODING] ? to_gray(mt_trunc) : mt_trunc; // [RQ9]
        idx_code = m_reg.fmt[`BIT_MULTITURN_OUTPUT_CODING] ? (m_reg.idx ^ (m_reg.idx >> 1)) : m_reg.idx;
        field = idx_on ? {mt_code[`MT_COUNT_W-`IDX_W-1:0], idx_code} : mt_code; // [RQ12]
        n_sync = m_reg.opt[`FLD_SYNC_HI:`FLD_SYNC_LO]; // [RQ13]
        sync_bits = m_reg.pos >> (`SYNC_MAX - {1'b0, n_sync}); // [RQ16]
        n_bits = mt_w + {4'h0, n_sync};
        word = ((`WORD_W'(field) << n_sync) | `WORD_W'(sync_bits)) << (`WORD_W_SZ - n_bits);
    end

    always_comb
    begin
        m_next = m_reg;
        m_next.sens_s1 = {sensor_sin_pos_in, sensor_cos_pos_in, sensor_sin_gt_cos_in};
        m_next.sens_s2 = m_reg.sens_s1;
        m_next.ack_s1 = l_reg.ack_tgl;
        m_next.ack_s2 = m_reg.ack_s1;
        m_next.pos = adj_pos;
        m_next.pos_ok = 1'b1;
        // Period index and revolution count, direction already applied
        if (step_up)
        begin
            if (m_reg.idx == m_reg.per)
            begin
                m_next.idx = `IDX_W'(0);
                m_next.mt = m_reg.mt + `MT_COUNT_W'(1); // [RQ10] [RQ14]
            end
            else
            begin
                m_next.idx = m_reg.idx + `IDX_W'(1);
            end
        end
        else if (step_dn)
        begin
            if (m_reg.idx == `IDX_W'(0))
            begin
                m_next.idx = m_reg.per;
                m_next.mt = m_reg.mt - `MT_COUNT_W'(1); // [RQ10] [RQ3]
            end
            else
            begin
                m_next.idx = m_reg.idx - `IDX_W'(1);
            end
        end
        // Publish a new word once the link has taken the previous one
        if (m_reg.pub_tgl == m_reg.ack_s2)
        begin
            m_next.pub_word = word;
            m_next.pub_tgl = ~m_reg.pub_tgl;
        end
        if (cfg_wr_in)
        begin
            unique case (cfg_addr_in)
                `REG_FORMAT_ADDR: m_next.fmt = cfg_wr_data_in;
                `REG_WIDTH_ADDR: m_next.wid = cfg_wr_data_in;
                `REG_PERIODS_ADDR: m_next.per = cfg_wr_data_in;
                `REG_OPTIONS_ADDR: m_next.opt = cfg_wr_data_in;
                default: ;
            endcase
        end
        unique case (cfg_rd_addr_in)
            `REG_FORMAT_ADDR: m_next.rd_data = m_reg.fmt;
            `REG_WIDTH_ADDR: m_next.rd_data = m_reg.wid;
            `REG_PERIODS_ADDR: m_next.rd_data = m_reg.per;
            `REG_OPTIONS_ADDR: m_next.rd_data = m_reg.opt;
            default: m_next.rd_data = 8'h00;
        endcase
        if (sys_rst_in)
        begin
            m_next.fmt = `RST_FORMAT;
            m_next.wid = `RST_WIDTH;
            m_next.per = `RST_PERIODS;
            m_next.opt = `RST_OPTIONS;
            m_next.pos = `POS_MIN;
            m_next.pos_ok = 1'b0;
            m_next.idx = `IDX_W'(0);
            m_next.mt = `MT_COUNT_W'(0);
            m_next.pub_word = `WORD_W'(0);
            m_next.pub_tgl = 1'b0;
            m_next.rd_data = 8'h00;
        end
    end

    always_ff @(posedge clk_in)
    begin
        m_reg <= m_next;
    end

    // Chain input decoded serially from Gray when selected
    always_comb
    begin
        chain_in_bit = 1'b0; // [RQ4]
        if (l_reg.mode_s2[0])
        begin
            chain_in_bit = l_reg.mode_s2[1] ? (chain_serial_input_in ^ l_reg.gray_prev)
                                            : chain_serial_input_in; // [RQ7]
        end
    end

    always_comb
    begin
        l_next = l_reg;
        l_next.rst_s1 = sys_rst_in;
        l_next.rst_s2 = l_reg.rst_s1;
        l_next.tgl_s1 = m_reg.pub_tgl;
        l_next.tgl_s2 = l_reg.tgl_s1;
        l_next.sel_s1 = mode_select_in;
        l_next.sel_s2 = l_reg.sel_s1;
        l_next.mode_s1 = {m_reg.fmt[`BIT_SINGLETURN_INPUT_CODING], m_reg.fmt[`BIT_CHAIN_MODE]}; // [RQ6]
        l_next.mode_s2 = l_reg.mode_s1;
        if (l_reg.tgl_s2 != l_reg.ack_tgl)
        begin
            l_next.word = m_reg.pub_word;
            l_next.ack_tgl = l_reg.tgl_s2;
        end
        unique case (l_reg.state)
            serial_format_pkg::LINK_IDLE:
            begin
                if (ssi_frame_in && !l_reg.sel_s2) // [RQ15]
                begin
                    l_next.sh = l_reg.word; // [RQ4]
                    l_next.gray_prev = 1'b0;
                    l_next.state = serial_format_pkg::LINK_SHIFT;
                end
            end
            serial_format_pkg::LINK_SHIFT:
            begin
                if (ssi_frame_in)
                begin
                    l_next.sh = {l_reg.sh[`WORD_W-2:0], chain_in_bit}; // [RQ5]
                    l_next.gray_prev = chain_in_bit;
                end
                else
                begin
                    l_next.state = serial_format_pkg::LINK_IDLE;
                end
            end
        endcase
        if (l_reg.rst_s2)
        begin
            l_next.state = serial_format_pkg::LINK_IDLE;
            l_next.ack_tgl = 1'b0;
            l_next.word = `WORD_W'(0);
            l_next.sh = `WORD_W'(0);
            l_next.gray_prev = 1'b0;
        end
    end

    always_ff @(posedge ssi_clk_in)
    begin
        l_reg <= l_next;
    end

    // Data line idles high outside an active frame
    assign ssi_data_out = (ssi_frame_in && (l_reg.state == serial_format_pkg::LINK_SHIFT))
                          ? l_reg.sh[`WORD_W-1] : 1'b1; // [RQ15] [RQ5]
    assign slave_access_lock_out = m_reg.fmt[`BIT_SINGLETURN_INPUT_CODING] && !m_reg.fmt[`BIT_CHAIN_MODE]; // [RQ8]
    assign cfg_rd_data_out = m_reg.rd_data;
    assign position_out = m_reg.pos;
    assign period_index_out = m_reg.idx;
    assign mt_count_out = m_reg.mt;

    property p_offset_dir;
        @(posedge clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) && $stable(m_reg.sens_s2)
        && $stable(m_reg.wid) && $stable(m_reg.fmt)
        |-> position_out == 3'(m_reg.wid[`FLD_SHIFT_HI:`FLD_SHIFT_LO]
            + (m_reg.fmt[`BIT_DIR] ? (`POS_MIN - raw_pos) : raw_pos));
    endproperty
    a_offset_dir: assert property (p_offset_dir) // [RQ2] [RQ3]
        else $error("position offset or direction wrong");

    property p_count_up;
        @(posedge clk_in) disable iff (sys_rst_in)
        step_up && (m_reg.idx == m_reg.per) && !cfg_wr_in
        |=> (mt_count_out == $past(mt_count_out) + `MT_COUNT_W'(1)) && (period_index_out == 8'h00);
    endproperty
    a_count_up: assert property (p_count_up) // [RQ10]
        else $error("revolution count did not advance");

    property p_count_dn;
        @(posedge clk_in) disable iff (sys_rst_in)
        step_dn && (m_reg.idx == 8'h00) && !cfg_wr_in
        |=> (mt_count_out == $past(mt_count_out) - `MT_COUNT_W'(1))
            && (period_index_out == $past(m_reg.per));
    endproperty
    a_count_dn: assert property (p_count_dn) // [RQ3]
        else $error("revolution count did not step back");

    property p_width_min;
        @(posedge clk_in) disable iff (sys_rst_in)
        (m_reg.wid[`FLD_MTW_HI:`FLD_MTW_LO] == 5'h00) && (n_sync == 2'h0)
        |-> word[`WORD_W-10:0] == 34'h0;
    endproperty
    a_width_min: assert property (p_width_min) // [RQ11]
        else $error("short field carries extra bits");

    property p_index_lsbs;
        @(posedge clk_in) disable iff (sys_rst_in)
        idx_on && !m_reg.fmt[`BIT_MULTITURN_OUTPUT_CODING] |-> field[`IDX_W-1:0] == m_reg.idx;
    endproperty
    a_index_lsbs: assert property (p_index_lsbs) // [RQ12]
        else $error("period index not in low bits");

    property p_sync_tail;
        @(posedge clk_in) disable iff (sys_rst_in)
        (n_sync == 2'h3) |-> word[`WORD_W-1-n_bits+3 -: 3] == m_reg.pos;
    endproperty
    a_sync_tail: assert property (p_sync_tail) // [RQ13] [RQ16]
        else $error("sync bits not position MSBs");

    property p_lock;
        @(posedge clk_in) disable iff (sys_rst_in)
        cfg_wr_in && (cfg_addr_in == `REG_FORMAT_ADDR)
        |=> slave_access_lock_out == ($past(cfg_wr_data_in[`BIT_SINGLETURN_INPUT_CODING])
            && !$past(cfg_wr_data_in[`BIT_CHAIN_MODE]));
    endproperty
    a_lock: assert property (p_lock) else $error("access lock does not follow format"); // [RQ8]

    property p_readout_ignores_input;
        @(posedge ssi_clk_in) disable iff (l_reg.rst_s2)
        (l_reg.state == serial_format_pkg::LINK_SHIFT) && ssi_frame_in && !l_reg.mode_s2[0]
        |=> l_reg.sh[0] == 1'b0;
    endproperty
    a_readout_ignores_input: assert property (p_readout_ignores_input) // [RQ4]
        else $error("input leaked in readout mode");

    property p_chain_shift;
        @(posedge ssi_clk_in) disable iff (l_reg.rst_s2)
        (l_reg.state == serial_format_pkg::LINK_SHIFT) && ssi_frame_in && (l_reg.mode_s2 == 2'h1)
        |=> (l_reg.sh[`WORD_W-1:1] == $past(l_reg.sh[`WORD_W-2:0]))
            && (l_reg.sh[0] == $past(chain_serial_input_in));
    endproperty
    a_chain_shift: assert property (p_chain_shift) // [RQ5]
        else $error("shift register did not advance");

    property p_chain_gray;
        @(posedge ssi_clk_in) disable iff (l_reg.rst_s2)
        (l_reg.state == serial_format_pkg::LINK_SHIFT) && ssi_frame_in && (l_reg.mode_s2 == 2'h3)
        |=> l_reg.sh[0] == ($past(chain_serial_input_in) ^ $past(l_reg.gray_prev));
    endproperty
    a_chain_gray: assert property (p_chain_gray) // [RQ7]
        else $error("chain input not Gray decoded");

    property p_select_idle;
        @(posedge ssi_clk_in) disable iff (l_reg.rst_s2)
        l_reg.sel_s2 && (l_reg.state == serial_format_pkg::LINK_IDLE) |=> ssi_data_out == 1'b1;
    endproperty
    a_select_idle: assert property (p_select_idle) // [RQ15]
        else $error("link active with select high");

endmodule

`default_nettype wire

//--- tb/ssi_master_model.sv
// Serial master and singleturn source facing the link
`timescale 1ns/10ps
`default_nettype none

module ssi_master_model
(
    // Link
    output logic ssi_clk_out,
    output logic ssi_frame_out,
    output logic chain_out,
    input wire logic data_in
);
    logic [63:0] rx;

    initial
    begin
        ssi_clk_out = 1'b0;
        ssi_frame_out = 1'b0;
        chain_out = 1'b0;
    end

    // Free link edges, 48 ns period
    task automatic edges(input int n);
        repeat (n)
        begin
            #24 ssi_clk_out = 1'b1;
            #24 ssi_clk_out = 1'b0;
        end
    endtask

    // One frame; singleturn bits go out MSB first
    task automatic frame(input int n, input logic [63:0] st);
        edges(12);
        rx = '0;
        for (int i = 0; i < n; i++)
        begin
            ssi_frame_out = 1'b1;
            chain_out = st[63-i];
            #24 ssi_clk_out = 1'b1;
            #24 rx[63-i] = data_in;
            ssi_clk_out = 1'b0;
        end
        ssi_frame_out = 1'b0;
        chain_out = ~chain_out;
        edges(1);
    endtask
endmodule
`default_nettype wire

//--- tb/multiturn_serial_output_format_bench.sv
// Self-checking bench for the multiturn serial output formatter
`timescale 1ns/10ps
`default_nettype none

module multiturn_serial_output_format_bench;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ssi_clk, ssi_frame, chain_bit, data_bit, lock;
    logic sin_p = 1'b1, cos_p = 1'b1, sgc = 1'b0, sel = 1'b0, wr_en = 1'b0;
    logic [2:0] wa = 3'h0, ra = 3'h0, pos;
    logic [7:0] wd = 8'h00, rd, idx;
    logic [39:0] mt;
    logic [2:0] sec_tab [8] = '{3'h6, 3'h7, 3'h5, 3'h4, 3'h0, 3'h1, 3'h3, 3'h2};
    int n_mismatch = 0;
    int comparisons = 0;

    always #25 clk_in = ~clk_in;

    multiturn_serial_output_format i_dut
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ssi_clk_in(ssi_clk),
        .ssi_frame_in(ssi_frame),
        .chain_serial_input_in(chain_bit),
        .ssi_data_out(data_bit),
        .sensor_sin_pos_in(sin_p),
        .sensor_cos_pos_in(cos_p),
        .sensor_sin_gt_cos_in(sgc),
        .mode_select_in(sel),
        .cfg_wr_in(wr_en),
        .cfg_addr_in(wa),
        .cfg_wr_data_in(wd),
        .cfg_rd_addr_in(ra),
        .cfg_rd_data_out(rd),
        .position_out(pos),
        .period_index_out(idx),
        .mt_count_out(mt),
        .slave_access_lock_out(lock)
    );

    ssi_master_model i_ssi
    (
        .ssi_clk_out(ssi_clk),
        .ssi_frame_out(ssi_frame),
        .chain_out(chain_bit),
        .data_in(data_bit)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en <= 1'b1;
        wa <= a;
        wd <= d;
        @(posedge clk_in);
        wr_en <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        ra <= a;
        repeat (2) @(posedge clk_in);
        #1 check("cfg_rd_data_out", {56'h0, rd}, {56'h0, exp});
    endtask

    // Sensor signs for the middle of sector k
    task automatic step(input int k);
        @(posedge clk_in);
        {sin_p, cos_p, sgc} <= sec_tab[k % 8];
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic turn(input int periods);
        for (int k = 1; k <= 8 * periods; k++)
            step(k);
    endtask

    task automatic test_regs;
        rdchk(3'h0, 8'h00);
        rdchk(3'h1, 8'h00);
        rdchk(3'h5, 8'h00);
        wr(3'h2, 8'h3C);
        rdchk(3'h2, 8'h3C);
        wr(3'h3, 8'h77);
        rdchk(3'h3, 8'h00);
        wr(3'h2, 8'h00);
    endtask

    task automatic test_count;
        logic [39:0] m0;
        turn(2);
        check("mt_count_out", mt, 40'h2);
        wr(3'h0, 8'h08);
        m0 = mt;
        turn(1);
        check("mt_count_out", mt, m0 - 40'h1);
        wr(3'h0, 8'h00);
    endtask

    task automatic test_offset;
        logic [2:0] p0;
        step(2);
        p0 = pos;
        step(3);
        check("position_out", pos, p0 + 3'h1);
        for (int s = 0; s < 8; s++)
        begin
            wr(3'h1, 8'(s << 5));
            check("position_out", pos, 3'(p0 + 3'h1 + 3'(s)));
        end
        wr(3'h1, 8'h00);
        step(0);
    endtask

    task automatic test_lock;
        for (int f = 0; f < 8; f++)
        begin
            wr(3'h0, 8'(f));
            check("slave_access_lock_out", lock, f == 4 || f == 6);
        end
    endtask

    task automatic test_frame(input logic [7:0] f, w, o, p, input logic [63:0] st);
        int n, s, l;
        logic [39:0] c;
        logic [7:0] x, d;
        logic [63:0] e;
        wr(3'h0, f);
        wr(3'h1, w);
        wr(3'h2, p);
        wr(3'h5, o);
        n = int'(w[4:0]) + 9;
        s = int'(o[5:4]);
        l = n + s + 8;
        c = mt;
        x = idx;
        if (o[6] && p != 8'h00)
            n = n - 8;
        c = c & ~(40'hFFFFFFFFFF << n);
        if (f[1])
        begin
            c = c ^ (c >> 1);
            x = x ^ (x >> 1);
        end
        e = {24'h0, c} << (64 - n);
        if (o[6] && p != 8'h00)
        begin
            e = e | ({56'h0, x} << (56 - n));
            n = n + 8;
        end
        e = e | (({61'h0, pos} >> (3 - s)) << (64 - n - s));
        d = st[62:55];
        if (f[2])
            for (int i = 6; i >= 0; i--)
                d[i] = d[i+1] ^ d[i];
        // Chain bits leave only after the whole 43-bit shift register
        if (f[0])
        begin
            l = 51;
            e = e | ({56'h0, d} << 13);
        end
        i_ssi.frame(l, st);
        check("ssi_data_out", i_ssi.rx & ~(64'hFFFFFFFFFFFFFFFF >> l), e);
    endtask

    task automatic test_select;
        @(posedge clk_in);
        sel <= 1'b1;
        i_ssi.frame(16, 64'h0);
        check("ssi_data_out", {48'h0, i_ssi.rx[63:48]}, 64'hFFFF);
        @(posedge clk_in);
        sel <= 1'b0;
    endtask

    initial
    begin
        fork
            i_ssi.edges(8);
        join_none
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        test_regs();
        test_count();
        test_offset();
        test_lock();
        test_frame(8'h00, 8'h00, 8'h30, 8'h00, 64'hA5C3);
        test_frame(8'h02, 8'h1F, 8'h10, 8'h00, 64'h0);
        test_frame(8'h01, 8'h03, 8'h20, 8'h00, 64'hB4 << 56);
        test_frame(8'h05, 8'h00, 8'h40, 8'h00, 64'h9C << 56);
        wr(3'h2, 8'h01);
        turn(1);
        step(5);
        test_frame(8'h02, 8'h08, 8'h70, 8'h01, 64'h0);
        test_select();
        conclude();
    end

    // Cuts a hung run short
    initial
    begin
        #2000000;
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
